// *** motor_config_nvm_serial_port.sv ***
// serial configuration port, two stored configuration registers and
// the loop filter whose coefficients they hold.
// assumes serial_clk runs only during frames; pins are asynchronous.
`timescale 1ns/10ps

//
// Contract
// - serial port active only while test mode input is high
// - every access is one sixteen-bit frame
// - three address/rw bits, five low bits, eight data bits
// - interface arms only on rising transfer enable
// - serial input sampled on each serial clock rising edge
// - read data shifted out on serial clock rising edges
// - program strobe after enable falls copies holding word to register
// - read returns register contents at the time of reading
// - register bit 0 maps to frame data bit zero
// - address 0: zero code, coast, sync rectification, gain select
// - address 1 bits 7..2 hold lead coefficient, default 28
// - address 1 low bits hold speed sensor frequency select
// - zero coefficient equals 120 plus code, default code 4
// - filter out = in*(128z - zero)*0.25 / (z - lead/128)
// - 10-bit input, 17-bit filter, 8-bit duty word
// - sample period adjustable from 250 us to 1 ms
// - address bits lsb first, third bit 1 read, 0 write
module motor_config_nvm_serial_port
  import motor_config_nvm_pkg::*;
#(
  parameter logic [7:0] LOOP_RESET      = LOOP_AND_DRIVE_CONFIG_RST,
  parameter logic [7:0] POLE_RESET      = FILTER_POLE_AND_SPEED_SELECT_RST,
  parameter int         SAMPLE_BASE_CYC = SAMPLE_MIN_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   test_mode_in,
  input  wire logic                   serial_clk,
  input  wire logic                   transfer_enable_in,
  input  wire logic                   serial_in,
  output logic                        serial_out,
  output logic                        serial_out_en,
  input  wire logic                   program_strobe_in,
  input  wire logic [RATE_SEL_W-1:0]  sample_rate_sel,
  input  wire logic [IN_W-1:0]        integrator_in,
  output logic [DUTY_W-1:0]           duty_out,
  output logic                        sample_tick,
  output logic [ZERO_CODE_W-1:0]      zero_coefficient,
  output logic                        coast_enable,
  output logic                        sync_rect_enable,
  output logic [GAIN_SEL_W-1:0]       integrator_gain_select,
  output logic [LEAD_W-1:0]           lead_pole_coefficient,
  output logic [SPEED_SEL_W-1:0]      speed_sensor_feedback_select
);

  function automatic logic signed [ACC_W-1:0] clamp(
    input logic signed [ACC_W-1:0] v,
    input logic signed [ACC_W-1:0] lo,
    input logic signed [ACC_W-1:0] hi
  );
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  ////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link domain: shift in, shift out
  logic                  link_clr_n;
  logic                  armed_q, armed_d;
  logic [CNT_W-1:0]      bit_cnt_q, bit_cnt_d;
  logic [FRAME_BITS-1:0] frame_q, frame_d;
  logic                  so_q, so_d;
  logic                  so_en_q, so_en_d;
  logic [FRAME_BITS-1:0] hold_q, hold_d;
  logic                  frame_tog_q, frame_tog_d;
  logic [FRAME_BITS-1:0] rd_s1_q;
  logic [FRAME_BITS-1:0] rd_s2_q;
  logic [DATA_W-1:0]     rd_word;
  logic [DATA_W-1:0]     cfg_q [2];

  // enable low or test mode low holds the link idle between frames
  // armed only once enable was seen low in test mode, so a standing level is no edge
  assign link_clr_n = rst_n & armed_q & transfer_enable_in & test_mode_in;

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    frame_d   = frame_q;
    so_d      = so_q;
    so_en_d   = so_en_q;
    // unmapped address reads as zero
    rd_word   = frame_q[ADDR_MSB_POS] ? '0 :
                (frame_q[ADDR_LSB_POS] ? rd_s2_q[15:8] : rd_s2_q[7:0]);
    if (bit_cnt_q < CNT_W'(FRAME_BITS)) begin
      frame_d[bit_cnt_q[3:0]] = serial_in;
      bit_cnt_d               = bit_cnt_q + 1'b1;
    end
    if (bit_cnt_q >= CNT_W'(DATA_LSB) && bit_cnt_q < CNT_W'(FRAME_BITS)) begin
      so_en_d = (frame_q[RW_POS] == RW_READ);
      so_d    = rd_word[bit_cnt_q[2:0]];
    end else if (bit_cnt_q >= CNT_W'(FRAME_BITS)) begin
      so_en_d = 1'b0;
      so_d    = 1'b0;
    end
  end

  always_ff @(posedge serial_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_cnt_q <= '0;
      frame_q   <= '0;
      so_q      <= 1'b0;
      so_en_q   <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      frame_q   <= frame_d;
      so_q      <= so_d;
      so_en_q   <= so_en_d;
    end
  end

  // holding word survives the enable drop so the strobe can use it
  always_comb begin
    hold_d      = hold_q;
    frame_tog_d = frame_tog_q;
    if (bit_cnt_q == CNT_W'(FRAME_BITS - 1)) begin
      hold_d      = frame_d;
      frame_tog_d = ~frame_tog_q;
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q      <= '0;
      frame_tog_q <= 1'b0;
      rd_s1_q     <= '0;
      rd_s2_q     <= '0;
    end else begin
      hold_q      <= hold_d;
      frame_tog_q <= frame_tog_d;
      // registers only change outside frames, so two edges settle them
      rd_s1_q     <= {cfg_q[1], cfg_q[0]};
      rd_s2_q     <= rd_s1_q;
    end
  end

  assign serial_out    = so_q;
  assign serial_out_en = so_en_q;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages, change once stages 2 and 3 agree
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0] pin_q, pin_d;
  logic [2:0] tog_q, tog_d;
  logic       test_q, sien_q, vpp_q;
  logic       vpp_prev_q;

  assign pin_raw = {program_strobe_in, transfer_enable_in, test_mode_in};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s2_q[i] : pin_q[i];
    end
    tog_d = {tog_q[1:0], frame_tog_q};
    // enable already high at test entry must not open a frame
    armed_d = armed_q;
    if (!test_q) begin
      armed_d = 1'b0;
    end else if (!sien_q) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_s3_q   <= '0;
      pin_q      <= '0;
      tog_q      <= '0;
      vpp_prev_q <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      pin_s1_q   <= pin_raw;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_q      <= pin_d;
      tog_q      <= tog_d;
      vpp_prev_q <= vpp_q;
      armed_q    <= armed_d;
    end
  end

  assign test_q = pin_q[0];
  assign sien_q = pin_q[1];
  assign vpp_q  = pin_q[2];

  ////////////////////////////////////////////////////////////////////
  // pending write and commit
  logic              frame_evt;
  logic              commit;
  logic              pend_q, pend_d;
  logic [1:0]        pend_addr_q, pend_addr_d;
  logic [DATA_W-1:0] pend_data_q, pend_data_d;
  logic [DATA_W-1:0] cfg_d [2];

  assign frame_evt = tog_q[2] ^ tog_q[1];
  // a strobe with enable still high is not a commit
  assign commit    = pend_q && test_q && !sien_q && vpp_q && !vpp_prev_q;

  always_comb begin
    pend_d      = pend_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    cfg_d       = cfg_q;
    if (commit) begin
      pend_d = 1'b0;
      if (pend_addr_q == LOOP_AND_DRIVE_CONFIG_OFS) begin
        cfg_d[0] = pend_data_q;
      end else if (pend_addr_q == FILTER_POLE_AND_SPEED_SELECT_OFS) begin
        cfg_d[1] = pend_data_q;
      end
    end
    if (!test_q) begin
      pend_d = 1'b0;
    end else if (frame_evt) begin
      // a new frame wins over a commit's clear in the same cycle; test mode low still clears it
      pend_d      = (hold_q[RW_POS] != RW_READ);
      pend_addr_d = hold_q[ADDR_MSB_POS:ADDR_LSB_POS];
      pend_data_d = hold_q[DATA_LSB +: DATA_W];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q      <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
      cfg_q[0]    <= LOOP_RESET;
      cfg_q[1]    <= POLE_RESET;
    end else begin
      pend_q      <= pend_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      cfg_q       <= cfg_d;
    end
  end

  assign zero_coefficient       = cfg_q[0][ZERO_CODE_LSB +: ZERO_CODE_W];
  assign coast_enable           = cfg_q[0][COAST_POS];
  assign sync_rect_enable       = cfg_q[0][SYNC_RECT_POS];
  assign integrator_gain_select = cfg_q[0][GAIN_SEL_LSB +: GAIN_SEL_W];
  assign lead_pole_coefficient  = cfg_q[1][LEAD_LSB +: LEAD_W];
  assign speed_sensor_feedback_select = cfg_q[1][SPEED_SEL_LSB +: SPEED_SEL_W];

  ////////////////////////////////////////////////////////////////////
  // sample timer
  logic [SAMPLE_CNT_W-1:0] samp_cnt_q, samp_cnt_d;
  logic [SAMPLE_CNT_W-1:0] samp_last;
  logic                    tick_q, tick_d;

  // period = base * (sel + 1): 250, 500, 750 or 1000 us
  assign samp_last = SAMPLE_CNT_W'(SAMPLE_BASE_CYC * (int'(sample_rate_sel) + 1) - 1);

  always_comb begin
    tick_d     = 1'b0;
    samp_cnt_d = samp_cnt_q + 1'b1;
    if (samp_cnt_q >= samp_last) begin
      samp_cnt_d = '0;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      samp_cnt_q <= samp_cnt_d;
      tick_q     <= tick_d;
    end
  end

  assign sample_tick = tick_q;

  ////////////////////////////////////////////////////////////////////
  // loop filter: y = (lead/128) y' + 0.25 (128 x - zero x')
  logic signed [ACC_W-1:0]  lead_s, zero_s, x_s, xp_s, fb, fw, sum;
  logic [IN_W-1:0]          xp_q, xp_d;
  logic signed [FILT_W-1:0] y_q, y_d;
  logic [DUTY_W-1:0]        duty_q, duty_d;
  logic signed [ACC_W-1:0]  duty_w;

  always_comb begin
    lead_s = ACC_W'(lead_pole_coefficient);
    zero_s = ACC_W'(ZERO_BASE + 8'(zero_coefficient));
    x_s    = ACC_W'(integrator_in);
    xp_s   = ACC_W'(xp_q);
    fb     = (lead_s * ACC_W'(y_q)) >>> POLE_SHIFT;
    fw     = ((x_s <<< LEAD_SHIFT) - zero_s * xp_s) >>> GAIN_SHIFT;
    sum    = fb + fw;
    xp_d   = xp_q;
    y_d    = y_q;
    duty_d = duty_q;
    duty_w = '0;
    if (tick_q) begin
      xp_d   = integrator_in;
      y_d    = FILT_W'(clamp(sum, -(ACC_W'(1) <<< (FILT_W - 1)),
                             (ACC_W'(1) <<< (FILT_W - 1)) - 1));
      duty_w = clamp(sum, '0, (ACC_W'(1) <<< DUTY_W) - 1);
      duty_d = DUTY_W'(duty_w);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xp_q   <= '0;
      y_q    <= '0;
      duty_q <= '0;
    end else begin
      xp_q   <= xp_d;
      y_q    <= y_d;
      duty_q <= duty_d;
    end
  end

  assign duty_out = duty_q;

endmodule : motor_config_nvm_serial_port

// *** motor_config_nvm_pkg.sv ***
// constants for the serial configuration port, the two stored
// configuration registers and the loop filter they steer.
// assumes a 200 MHz system clock and a free-standing serial clock.
package motor_config_nvm_pkg;

  ////////////////////////////////////////////////////////////////////
  // frame layout, first bit shifted is bit 0
  localparam int FRAME_BITS   = 16;
  localparam int CNT_W        = 5;
  localparam int ADDR_LSB_POS = 0;
  localparam int ADDR_MSB_POS = 1;
  localparam int RW_POS       = 2;
  localparam int DATA_LSB     = 8;
  localparam int DATA_W       = 8;
  localparam logic RW_READ    = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // register offsets and reset values
  localparam logic [1:0] LOOP_AND_DRIVE_CONFIG_OFS        = 2'h0;
  localparam logic [1:0] FILTER_POLE_AND_SPEED_SELECT_OFS = 2'h1;
  localparam logic [7:0] LOOP_AND_DRIVE_CONFIG_RST        = 8'h98;
  localparam logic [7:0] FILTER_POLE_AND_SPEED_SELECT_RST = 8'h70;

  // loop_and_drive_config fields
  localparam int ZERO_CODE_LSB = 5;
  localparam int ZERO_CODE_W   = 3;
  localparam int COAST_POS     = 4;
  localparam int SYNC_RECT_POS = 3;
  localparam int GAIN_SEL_LSB  = 0;
  localparam int GAIN_SEL_W    = 3;
  // filter_pole_and_speed_select fields
  localparam int LEAD_LSB      = 2;
  localparam int LEAD_W        = 6;
  localparam int SPEED_SEL_LSB = 0;
  localparam int SPEED_SEL_W   = 2;

  ////////////////////////////////////////////////////////////////////
  // loop filter
  localparam logic [7:0] ZERO_BASE = 8'h78;
  localparam int IN_W       = 10;
  localparam int FILT_W     = 17;
  localparam int DUTY_W     = 8;
  localparam int ACC_W      = 28;
  localparam int POLE_SHIFT = 7;
  localparam int LEAD_SHIFT = 7;
  localparam int GAIN_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////
  // sample period, 250 us to 1 ms in four steps
  localparam int MCLK_HZ        = 200_000_000;
  localparam int SAMPLE_MIN_US  = 250;
  localparam int SAMPLE_MAX_US  = 1000;
  localparam int SAMPLE_MIN_CYC = SAMPLE_MIN_US * (MCLK_HZ / 1_000_000);
  localparam int SAMPLE_CNT_W   = 18;
  localparam int RATE_SEL_W     = 2;

endpackage : motor_config_nvm_pkg

// *** motor_config_nvm_checker.sv ***
// port-level checks of the configuration port and the sample tick.
// assumes binding to motor_config_nvm_serial_port.
`timescale 1ns/10ps
module motor_config_nvm_checker
  import motor_config_nvm_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = SAMPLE_MIN_CYC
) (
  input wire logic             mclk,
  input wire logic             resetn,
  input wire logic             test_mode_in,
  input wire logic             transfer_enable_in,
  input wire logic             program_strobe_in,
  input wire logic             serial_out_en,
  input wire logic             sample_tick,
  input wire logic [DUTY_W-1:0] duty_out,
  input wire logic [15:0]      cfg
);
  logic [3:0]  strobe_age_q;
  logic [3:0]  strobe_age_d;
  logic [19:0] gap_q;
  logic [19:0] gap_d;

  // saturating age so a stale strobe never excuses a change
  always_comb begin
    strobe_age_d = program_strobe_in ? 4'h0 : strobe_age_q + {3'h0, strobe_age_q != 4'hF};
    gap_d = sample_tick ? 20'h00000 : gap_q + 20'h00001;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strobe_age_q <= 4'hF;
      gap_q <= 20'h00000;
    end else begin
      strobe_age_q <= strobe_age_d;
      gap_q <= gap_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_tick; sample_tick; endsequence
  sequence s_quiet; !sample_tick [*8]; endsequence
  property p_tick_min_gap; s_tick |=> s_quiet; endproperty
  property p_tick_max_gap; gap_q <= 4 * SAMPLE_BASE_CYC + 4; endproperty
  property p_duty_on_tick; $changed(duty_out) |-> $past(sample_tick); endproperty
  property p_en_enable; serial_out_en |-> transfer_enable_in; endproperty
  property p_en_test; !test_mode_in [*4] |-> !serial_out_en; endproperty
  property p_commit_strobe; $changed(cfg) |-> strobe_age_q < 4'h8; endproperty
  property p_commit_enable;
    $changed(cfg) |-> !$past(transfer_enable_in) && !$past(transfer_enable_in, 4);
  endproperty
  property p_commit_test; $changed(cfg) |-> $past(test_mode_in, 2); endproperty

  a_tick_min_gap: assert property (p_tick_min_gap) else $error("tick too close");
  a_tick_max_gap: assert property (p_tick_max_gap) else $error("tick too late");
  a_duty_on_tick: assert property (p_duty_on_tick) else $error("duty off tick");
  a_en_enable: assert property (p_en_enable) else $error("drive without enable");
  a_en_test: assert property (p_en_test) else $error("drive outside test");
  a_commit_strobe: assert property (p_commit_strobe) else $error("change no strobe");
  a_commit_enable: assert property (p_commit_enable) else $error("change in frame");
  a_commit_test: assert property (p_commit_test) else $error("change outside test");
endmodule : motor_config_nvm_checker

bind motor_config_nvm_serial_port motor_config_nvm_checker #(
  .SAMPLE_BASE_CYC(SAMPLE_BASE_CYC)) u_chk (.mclk(mclk), .resetn(resetn),
  .test_mode_in(test_mode_in), .transfer_enable_in(transfer_enable_in),
  .program_strobe_in(program_strobe_in), .serial_out_en(serial_out_en),
  .sample_tick(sample_tick), .duty_out(duty_out),
  .cfg({zero_coefficient, coast_enable, sync_rect_enable, integrator_gain_select,
        lead_pole_coefficient, speed_sensor_feedback_select}));

// *** nvm_programmer.sv ***
// programmer model driving the serial test port and program strobe.
// assumes the bench calls one task at a time.
`timescale 1ns/10ps
module nvm_programmer (
  output logic     test_mode_in,
  output logic     serial_clk,
  output logic     transfer_enable_in,
  output logic     serial_in,
  output logic     program_strobe_in,
  input wire logic serial_out
);
  initial begin
    test_mode_in = 1'b0;
    serial_clk = 1'b0;
    transfer_enable_in = 1'b0;
    serial_in = 1'b0;
    program_strobe_in = 1'b0;
  end
  task session(input logic on);
    #71 test_mode_in = on;
    #300;
  endtask : session
  // link clock stands still outside frames
  task frame(input logic [1:0] a, input logic rd, input logic [7:0] d,
             output logic [7:0] q);
    logic [15:0] w;
    w = {rd ? 8'h00 : d, 5'h00, rd, a};
    #37 transfer_enable_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      serial_in = w[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
      if (i > 7) q[i-8] = serial_out;
    end
    transfer_enable_in = 1'b0;
    serial_in = ~serial_in;
  endtask : frame
  // hold scaled down, the device does not time it
  task commit();
    #100 program_strobe_in = 1'b1;
    #200 program_strobe_in = 1'b0;
    #100;
  endtask : commit
endmodule : nvm_programmer

// *** motor_config_nvm_serial_port_bench.sv ***
// bench for the serial configuration port with a register model.
// assumes the programmer model and the bound checker.
`timescale 1ns/10ps
module motor_config_nvm_serial_port_bench import motor_config_nvm_pkg::*;;
  localparam int BASE = 20;
  logic mclk, resetn, test_mode_in, serial_clk, transfer_enable_in, serial_in;
  logic serial_out, serial_out_en, program_strobe_in, sample_tick;
  logic coast_enable, sync_rect_enable;
  logic [1:0] sample_rate_sel, speed_sensor_feedback_select;
  logic [9:0] integrator_in;
  logic [7:0] duty_out, q;
  logic [2:0] zero_coefficient, integrator_gain_select;
  logic [5:0] lead_pole_coefficient;
  logic [7:0] regs [2];
  logic [7:0] loop_cfg, pole_cfg;
  logic       so_line;
  logic       duty_due = 1'b0;
  int fail_count, checks_done, cyc, n;
  int y_m, xp_m, s_m, d_m;
  int unsigned rng = 91;

  assign loop_cfg = {zero_coefficient, coast_enable, sync_rect_enable, integrator_gain_select};
  assign pole_cfg = {lead_pole_coefficient, speed_sensor_feedback_select};
  // a released output shows the inverse, so a read also needs the enable
  assign so_line  = serial_out_en ? serial_out : ~serial_out;

  motor_config_nvm_serial_port #(.SAMPLE_BASE_CYC(BASE)) u_motor_config_nvm_serial_port (
    .mclk(mclk), .resetn(resetn), .test_mode_in(test_mode_in), .serial_clk(serial_clk),
    .transfer_enable_in(transfer_enable_in), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .program_strobe_in(program_strobe_in), .sample_rate_sel(sample_rate_sel),
    .integrator_in(integrator_in), .duty_out(duty_out), .sample_tick(sample_tick),
    .zero_coefficient(zero_coefficient), .coast_enable(coast_enable),
    .sync_rect_enable(sync_rect_enable), .integrator_gain_select(integrator_gain_select),
    .lead_pole_coefficient(lead_pole_coefficient),
    .speed_sensor_feedback_select(speed_sensor_feedback_select));
  nvm_programmer u_nvm_programmer (.test_mode_in(test_mode_in), .serial_clk(serial_clk),
    .transfer_enable_in(transfer_enable_in), .serial_in(serial_in),
    .program_strobe_in(program_strobe_in), .serial_out(so_line));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  // filter model, one result per tick, compared the cycle after
  always @(negedge mclk) begin
    if (duty_due) check("duty", duty_out, 8'(d_m));
    duty_due = 1'b0;
    if (sample_tick === 1'b1) begin
      s_m = ((int'(regs[1][7:2]) * y_m) >>> 7) +
            ((int'(integrator_in) * 128 - (120 + int'(regs[0][7:5])) * xp_m) >>> 2);
      y_m = s_m < -65536 ? -65536 : (s_m > 65535 ? 65535 : s_m);
      d_m = s_m < 0 ? 0 : (s_m > 255 ? 255 : s_m);
      xp_m = int'(integrator_in);
      duty_due = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : xs
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic fields();
    check("loop", loop_cfg, regs[0]);
    check("pole", pole_cfg, regs[1]);
  endtask : fields
  task automatic rd(input logic [1:0] a);
    u_nvm_programmer.frame(a, 1'b1, 8'h00, q);
    check("read", q, a < 2 ? regs[a[0]] : 8'h00);
  endtask : rd
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic c);
    u_nvm_programmer.frame(a, 1'b0, d, q);
    if (c) u_nvm_programmer.commit();
    if (c && a < 2) regs[a[0]] = d;
  endtask : wr
  task automatic tick_gap();
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (sample_tick !== 1'b1);
  endtask : tick_gap
  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    sample_rate_sel = 2'h0;
    integrator_in = 10'h000;
    regs[0] = LOOP_AND_DRIVE_CONFIG_RST;
    regs[1] = FILTER_POLE_AND_SPEED_SELECT_RST;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (8) @(posedge mclk);
    fields();
    u_nvm_programmer.session(1'b1);
    rd(2'h0);
    rd(2'h1);
    // address 2 on every third pass must be ignored
    for (int i = 0; i < 9; i++) begin
      wr(2'(i % 3), xs(), 1'b1);
      fields();
      rd(2'h0);
      rd(2'h1);
    end
    rd(2'h3);
    wr(2'h0, ~regs[0], 1'b0);
    rd(2'h0);
    u_nvm_programmer.commit();
    fields();
    u_nvm_programmer.session(1'b0);
    u_nvm_programmer.frame(2'h1, 1'b0, ~regs[1], q);
    u_nvm_programmer.commit();
    fields();
    u_nvm_programmer.session(1'b1);
    rd(2'h1);
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk);
      sample_rate_sel <= 2'(s);
      integrator_in <= {2'h0, xs()};
      tick_gap();
      tick_gap();
      check("period", n[7:0], 8'(BASE * (s + 1)));
    end
    complete_run();
  end
endmodule : motor_config_nvm_serial_port_bench
